// ==== page1_media_regs.sv ====
// APB register bank for page 1 fiber media, good-CRC counter and extended mode
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Read/write transmit fault bits, sent to partner
// - Partner fault bits captured, read-only
// - Bit 9 allows 1000BASE-X link-up
// - Bit 8 allows 100BASE-FX link-up
// - Far end fault bit, clears on read
// - Fiber settings act on SerDes port only
// - Packet-seen bit, clears on read
// - Good-CRC counter wraps after 9999
// - Counter resets to zero, clears on read
// - Four LED extended mode bits
// - Bit 11 enables blink after hold release
// - Bit 4 routes fast failure to pin
// - Bits 3:2 select crossover mode
module page1_media_regs
  import page1_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic serdes_media_i,
  input wire logic lp_fault_valid_i,
  input wire logic [1:0] lp_fault_i,
  input wire logic far_end_fault_i,
  input wire logic good_crc_pkt_i,
  input wire logic low_power_hold_input_i,
  input wire logic fast_fail_i,
  input wire logic shared_io_gpio_i,
  input wire logic shared_io_gpio_oe_i,
  input wire logic [3:0] signal_detect_pins_i,
  output logic [1:0] tx_fault_o,
  output logic allow_1000x_o,
  output logic allow_100fx_o,
  output logic [3:0] led_ext_mode_o,
  output logic led_blink_o,
  output logic shared_io_pin_nine_o,
  output logic shared_io_pin_nine_oe_o,
  output logic [1:0] crossover_o,
  output logic [3:0] signal_detect_o,
  output logic irq_o
);

  // Control and status storage
  logic [1:0] tx_fault_r;
  logic [1:0] lp_fault_r;
  logic allow_1000x_r;
  logic allow_100fx_r;
  logic far_end_r;
  logic pkt_seen_r;
  logic [13:0] good_cnt_r;
  logic [3:0] led_ext_r;
  logic reset_blink_r;
  logic fast_fail_en_r;
  logic [1:0] crossover_r;
  logic sigdet_pol_r;
  logic [IRQ_WIDTH-1:0] irq_stat_r;
  logic [IRQ_WIDTH-1:0] irq_mask_r;
  logic hold_d_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [1:0] tx_fault_out_r;
  logic allow_1000x_out_r;
  logic allow_100fx_out_r;
  logic [3:0] led_ext_out_r;
  logic led_blink_r;
  logic pin_nine_r;
  logic pin_nine_oe_r;
  logic [1:0] crossover_out_r;
  logic [3:0] sigdet_r;
  logic irq_r;

  // Byte-lane write enable for one of the two low lanes
  function automatic logic lane_we(input logic [3:0] strb, input int lane);
    lane_we = strb[lane];
  endfunction : lane_we

  // Bus decode; reads are taken on the access edge, writes land on the
  // completing edge, so a write and the master's pready sample coincide
  wire access_w = psel_i & penable_i & ~pready_r;
  wire done_w = psel_i & penable_i & pready_r;
  wire wr_w = done_w & pwrite_i;
  wire rd_w = access_w & ~pwrite_i;
  wire sel_fiber_w = (paddr_i == FIBER_MEDIA_CONTROL_ADDR);
  wire sel_cnt_w = (paddr_i == GOOD_CRC_COUNTER_ADDR);
  wire sel_ext_w = (paddr_i == EXTENDED_MODE_CONTROL_ADDR);
  wire sel_stat_w = (paddr_i == IRQ_STATUS_ADDR);
  wire sel_mask_w = (paddr_i == IRQ_MASK_ADDR);
  wire mapped_w = sel_fiber_w | sel_cnt_w | sel_ext_w | sel_stat_w | sel_mask_w;
  wire wr_lo_w = lane_we(pstrb_i, 0);
  wire wr_hi_w = lane_we(pstrb_i, 1);
  wire rd_fiber_w = rd_w & sel_fiber_w;
  wire rd_cnt_w = rd_w & sel_cnt_w;

  // Read images; reserved bits are constant zero
  wire [15:0] fiber_img_w = {tx_fault_r, lp_fault_r, 2'h0, allow_1000x_r, allow_100fx_r,
                             1'b0, far_end_r, 6'h00};
  wire [15:0] cnt_img_w = {pkt_seen_r, 1'b0, good_cnt_r};
  wire [15:0] ext_img_w = {led_ext_r, reset_blink_r, 6'h00, fast_fail_en_r, crossover_r,
                           1'b0, sigdet_pol_r};
  wire [15:0] rd_img_w = sel_fiber_w ? fiber_img_w :
                         sel_cnt_w ? cnt_img_w :
                         sel_ext_w ? ext_img_w :
                         sel_stat_w ? {13'h0000, irq_stat_r} :
                         sel_mask_w ? {13'h0000, irq_mask_r} : 16'h0000;

  // Counter wraps instead of saturating
  wire [13:0] cnt_inc_w = (good_cnt_r == GOOD_CNT_LAST) ? GOOD_CNT_RESET :
                          good_cnt_r + 14'h0001;
  // A packet in the read cycle starts the next count, so it is not lost
  wire [13:0] cnt_nxt = good_crc_pkt_i ? (rd_cnt_w ? 14'h0001 : cnt_inc_w) :
                        (rd_cnt_w ? GOOD_CNT_RESET : good_cnt_r);
  wire pkt_seen_nxt = good_crc_pkt_i | (pkt_seen_r & ~rd_cnt_w);
  // Fault events only count on the SerDes media path
  wire far_ev_w = far_end_fault_i & serdes_media_i;
  wire far_end_nxt = far_ev_w | (far_end_r & ~rd_fiber_w);
  wire lp_ev_w = lp_fault_valid_i & serdes_media_i;
  wire [1:0] lp_fault_nxt = lp_ev_w ? lp_fault_i : lp_fault_r;

  // Interrupt events; set wins over write-one-to-clear
  wire [IRQ_WIDTH-1:0] irq_ev_w = {good_crc_pkt_i, lp_ev_w & (lp_fault_i != lp_fault_r),
                                   far_ev_w};
  wire [IRQ_WIDTH-1:0] irq_clr_w = (wr_w & sel_stat_w & wr_lo_w) ?
                                   pwdata_i[IRQ_WIDTH-1:0] : {IRQ_WIDTH{1'b0}};
  wire [IRQ_WIDTH-1:0] irq_stat_nxt = irq_ev_w | (irq_stat_r & ~irq_clr_w);

  // Blink request on release of the low-power hold
  wire hold_release_w = hold_d_r & ~low_power_hold_input_i;
  wire led_blink_nxt = hold_release_w & reset_blink_r;

  // Shared pin nine: fast failure or general purpose I/O
  wire pin_nine_nxt = fast_fail_en_r ? fast_fail_i : shared_io_gpio_i;
  wire pin_nine_oe_nxt = fast_fail_en_r | shared_io_gpio_oe_i;

  // Reserved crossover code falls back to automatic
  wire [1:0] xover_nxt = (crossover_r == XOVER_MDI || crossover_r == XOVER_MDIX) ?
                         crossover_r : XOVER_AUTO;

  // Fiber media control writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_fault_r <= TX_FAULT_RESET;
      allow_1000x_r <= ALLOW_1000X_RESET;
      allow_100fx_r <= ALLOW_100FX_RESET;
    end else if (wr_w && sel_fiber_w && wr_hi_w) begin
      tx_fault_r <= pwdata_i[TX_FAULT_LSB +: 2];
      allow_1000x_r <= pwdata_i[ALLOW_1000X_BIT];
      allow_100fx_r <= pwdata_i[ALLOW_100FX_BIT];
    end
  end

  // Extended mode control writes, per byte lane
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      led_ext_r <= LED_EXT_RESET;
      reset_blink_r <= 1'b0;
      fast_fail_en_r <= 1'b0;
      crossover_r <= CROSSOVER_RESET;
      sigdet_pol_r <= 1'b0;
    end else if (wr_w && sel_ext_w) begin
      if (wr_hi_w) begin
        led_ext_r <= pwdata_i[LED_EXT_LSB +: 4];
        reset_blink_r <= pwdata_i[RESET_BLINK_BIT];
      end
      if (wr_lo_w) begin
        fast_fail_en_r <= pwdata_i[FAST_FAIL_BIT];
        crossover_r <= pwdata_i[CROSSOVER_LSB +: 2];
        sigdet_pol_r <= pwdata_i[SIGDET_POL_BIT];
      end
    end
  end

  // Hardware-set status and counter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lp_fault_r <= LP_FAULT_RESET;
      far_end_r <= 1'b0;
      pkt_seen_r <= 1'b0;
      good_cnt_r <= GOOD_CNT_RESET;
      irq_stat_r <= {IRQ_WIDTH{1'b0}};
      hold_d_r <= 1'b0;
    end else begin
      lp_fault_r <= lp_fault_nxt;
      far_end_r <= far_end_nxt;
      pkt_seen_r <= pkt_seen_nxt;
      good_cnt_r <= cnt_nxt;
      irq_stat_r <= irq_stat_nxt;
      hold_d_r <= low_power_hold_input_i;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_mask_r <= {IRQ_WIDTH{1'b0}};
    end else if (wr_w && sel_mask_w && wr_lo_w) begin
      irq_mask_r <= pwdata_i[IRQ_WIDTH-1:0];
    end
  end

  // Bus answer registered; ready one cycle after penable rises
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= access_w;
      pslverr_r <= access_w & ~mapped_w;
      prdata_r <= rd_w ? {16'h0000, rd_img_w} : 32'h0000_0000;
    end
  end

  // Registered outputs; fiber controls only drive on SerDes media
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_fault_out_r <= TX_FAULT_RESET;
      allow_1000x_out_r <= 1'b0;
      allow_100fx_out_r <= 1'b0;
      led_ext_out_r <= LED_EXT_RESET;
      led_blink_r <= 1'b0;
      pin_nine_r <= 1'b0;
      pin_nine_oe_r <= 1'b0;
      crossover_out_r <= XOVER_AUTO;
      sigdet_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      tx_fault_out_r <= serdes_media_i ? tx_fault_r : TX_FAULT_RESET;
      allow_1000x_out_r <= allow_1000x_r & serdes_media_i;
      allow_100fx_out_r <= allow_100fx_r & serdes_media_i;
      led_ext_out_r <= led_ext_r;
      led_blink_r <= led_blink_nxt;
      pin_nine_r <= pin_nine_nxt;
      pin_nine_oe_r <= pin_nine_oe_nxt;
      crossover_out_r <= xover_nxt;
      sigdet_r <= signal_detect_pins_i ^ {4{sigdet_pol_r}}; // Active-low option inverts
      irq_r <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign tx_fault_o = tx_fault_out_r;
  assign allow_1000x_o = allow_1000x_out_r;
  assign allow_100fx_o = allow_100fx_out_r;
  assign led_ext_mode_o = led_ext_out_r;
  assign led_blink_o = led_blink_r;
  assign shared_io_pin_nine_o = pin_nine_r;
  assign shared_io_pin_nine_oe_o = pin_nine_oe_r;
  assign crossover_o = crossover_out_r;
  assign signal_detect_o = sigdet_r;
  assign irq_o = irq_r;

endmodule : page1_media_regs
`default_nettype wire

// ==== page1_regs_pkg.sv ====
// Constants for the page 1 media control register bank
package page1_regs_pkg;
  // Register byte offsets (printed offsets are not all multiples of four: index * 4)
  localparam logic [7:0] FIBER_MEDIA_CONTROL_IDX = 8'h10;
  localparam logic [7:0] GOOD_CRC_COUNTER_IDX = 8'h12;
  localparam logic [7:0] EXTENDED_MODE_CONTROL_IDX = 8'h13;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h21;
  localparam logic [11:0] FIBER_MEDIA_CONTROL_ADDR = {2'h0, FIBER_MEDIA_CONTROL_IDX, 2'h0};
  localparam logic [11:0] GOOD_CRC_COUNTER_ADDR = {2'h0, GOOD_CRC_COUNTER_IDX, 2'h0};
  localparam logic [11:0] EXTENDED_MODE_CONTROL_ADDR = {2'h0, EXTENDED_MODE_CONTROL_IDX, 2'h0};
  localparam logic [11:0] IRQ_STATUS_ADDR = {2'h0, IRQ_STATUS_IDX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};
  // Fiber media control fields
  localparam int TX_FAULT_LSB = 14;
  localparam int LP_FAULT_LSB = 12;
  localparam int ALLOW_1000X_BIT = 9;
  localparam int ALLOW_100FX_BIT = 8;
  localparam int FAR_END_FAULT_BIT = 6;
  localparam logic [1:0] TX_FAULT_RESET = 2'h0;
  localparam logic [1:0] LP_FAULT_RESET = 2'h0;
  localparam logic ALLOW_1000X_RESET = 1'b1;
  localparam logic ALLOW_100FX_RESET = 1'b1;
  // Good CRC counter fields
  localparam int PKT_SEEN_BIT = 15;
  localparam logic [13:0] GOOD_CNT_RESET = 14'h0000;
  localparam logic [13:0] GOOD_CNT_LAST = 14'h270F;
  // Extended mode control fields
  localparam int LED_EXT_LSB = 12;
  localparam int RESET_BLINK_BIT = 11;
  localparam int FAST_FAIL_BIT = 4;
  localparam int CROSSOVER_LSB = 2;
  localparam int SIGDET_POL_BIT = 0;
  localparam logic [3:0] LED_EXT_RESET = 4'h0;
  localparam logic [1:0] CROSSOVER_RESET = 2'h0;
  // Crossover encodings
  localparam logic [1:0] XOVER_AUTO = 2'h0;
  localparam logic [1:0] XOVER_MDI = 2'h2;
  localparam logic [1:0] XOVER_MDIX = 2'h3;
  // Interrupt status bits
  localparam int IRQ_FAR_END_BIT = 0;
  localparam int IRQ_LP_FAULT_BIT = 1;
  localparam int IRQ_GOOD_PKT_BIT = 2;
  localparam int IRQ_WIDTH = 3;
endpackage : page1_regs_pkg

// ==== page1_media_checker.sv ====
// Port-level assertions for the page 1 media register bank
`timescale 1ns/1ns
`default_nettype none
module page1_media_checker
  import page1_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic serdes_media_i,
  input wire logic fast_fail_i,
  input wire logic shared_io_gpio_oe_i,
  input wire logic [1:0] tx_fault_o,
  input wire logic allow_1000x_o,
  input wire logic allow_100fx_o,
  input wire logic led_blink_o,
  input wire logic shared_io_pin_nine_o,
  input wire logic shared_io_pin_nine_oe_o,
  input wire logic [1:0] crossover_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Bus answer timing and data shape
  property p_ready_pulse; pready_o |=> !pready_o; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_one_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer after access");
  property p_err_data; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
  a_err_data: assert property (p_err_data) else $error("bad error answer");
  property p_idle_data; prdata_o[31:16] == 16'h0 && (pready_o || prdata_o == 32'h0); endproperty
  a_idle_data: assert property (p_idle_data) else $error("stray read data");
  // Pin-side relations
  property p_xover; crossover_o != 2'h1; endproperty
  a_xover: assert property (p_xover) else $error("reserved crossover driven");
  property p_gate; !$past(serdes_media_i) |-> {tx_fault_o, allow_1000x_o, allow_100fx_o} == 4'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("fiber outputs without SerDes");
  property p_pin; shared_io_pin_nine_oe_o && !$past(shared_io_gpio_oe_i)
    |-> shared_io_pin_nine_o == $past(fast_fail_i); endproperty
  a_pin: assert property (p_pin) else $error("pin nine not fast failure");
  property p_blink; led_blink_o |=> !led_blink_o; endproperty
  a_blink: assert property (p_blink) else $error("blink not a pulse");
  c_err: cover property (pslverr_o);
  c_blink: cover property (led_blink_o);
  c_fiber: cover property (allow_1000x_o && tx_fault_o == 2'h3);
endmodule : page1_media_checker
bind page1_media_regs page1_media_checker chk (.*);
`default_nettype wire

// ==== tb_phy_ext_page1_media_ctrl_regs.sv ====
// Self-checking bench for the page 1 media register bank
`timescale 1ns/1ns
`default_nettype none
module tb_phy_ext_page1_media_ctrl_regs
  import page1_regs_pkg::*;
;
  logic clk_i = 1'h0, reset_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
  logic [3:0] pstrb_i = 4'hF, signal_detect_pins_i = 4'h0, led_ext_mode_o, signal_detect_o, sd;
  logic serdes_media_i = 1'h0, lp_fault_valid_i = 1'h0, far_end_fault_i = 1'h0, rerr;
  logic good_crc_pkt_i = 1'h0, low_power_hold_input_i = 1'h0, fast_fail_i = 1'h0;
  logic shared_io_gpio_i = 1'h0, shared_io_gpio_oe_i = 1'h0;
  logic [1:0] lp_fault_i = 2'h0, tx_fault_o, crossover_o;
  logic pready_o, pslverr_o, allow_1000x_o, allow_100fx_o, led_blink_o, irq_o;
  logic shared_io_pin_nine_o, shared_io_pin_nine_oe_o;
  logic [15:0] v;
  int err_count = 0, checked = 0, cyc = 0, blinks, pkt_cnt;
  // Model: reset image of each register, in address order
  int rst_q[$] = '{32'h0300, 0, 0, 0, 0};
  logic [11:0] addrs [5] = '{FIBER_MEDIA_CONTROL_ADDR, GOOD_CRC_COUNTER_ADDR,
    EXTENDED_MODE_CONTROL_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR};
  always #25 clk_i = ~clk_i;
  page1_media_regs dut (.*);
  task automatic tally_and_finish();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; pready and read data are taken at the rising edge only,
  // and only the bench's hang guard ends a wait that never gets an answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    @(posedge clk_i);
    while (pready_o !== 1'h1) begin
      @(posedge clk_i);
    end
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'h0, a, 32'h0);
    chk(n, e, rdat);
  endtask : rd
  task automatic settle();
    repeat (3) @(negedge clk_i);
  endtask : settle
  task automatic ev(input logic f, input logic l, input logic p);
    far_end_fault_i <= f;
    lp_fault_valid_i <= l;
    good_crc_pkt_i <= p;
    repeat (p ? pkt_cnt : 1) @(posedge clk_i);
    {far_end_fault_i, lp_fault_valid_i, good_crc_pkt_i} <= 3'h0;
    @(posedge clk_i);
  endtask : ev
  // Hang guard: well above the run's length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    // Page register sits outside the block; page 1 is taken as selected
    void'($urandom(32'h76B4B274));
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'h1;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) rd(addrs[i], rst_q[i], "reset");
    apb(1'h0, 12'h044, 32'h0);
    chk("unmapped", 32'h1, {rdat[30:0], rerr});
    // Fiber fields, with and without SerDes media; RO and reserved bits ignore writes
    for (int i = 0; i < 4; i++) begin
      v = i[0] ? 16'hFFFF : 16'h3CFF;
      serdes_media_i <= i[1];
      apb(1'h1, FIBER_MEDIA_CONTROL_ADDR, {16'h0, v});
      rd(FIBER_MEDIA_CONTROL_ADDR, {16'h0, v & 16'hC300}, "fiber");
      settle();
      chk("fiber out", i == 3 ? 32'hF : 32'h0, 32'({tx_fault_o, allow_1000x_o, allow_100fx_o}));
      @(posedge clk_i);
    end
    lp_fault_i <= 2'h2;
    ev(1'h1, 1'h1, 1'h0);
    rd(FIBER_MEDIA_CONTROL_ADDR, 32'hC300 | 32'h2 << LP_FAULT_LSB | 32'h40, "fault");
    rd(FIBER_MEDIA_CONTROL_ADDR, 32'hE300, "fault clr");
    serdes_media_i <= 1'h0;
    ev(1'h1, 1'h0, 1'h0);
    rd(FIBER_MEDIA_CONTROL_ADDR, 32'hE300, "fault gated");
    v = 16'($urandom) & 16'hFFF3 | 16'h0008;
    apb(1'h1, EXTENDED_MODE_CONTROL_ADDR, {16'h0, v});
    rd(EXTENDED_MODE_CONTROL_ADDR, {16'h0, v & 16'hF81D}, "ext");
    // LED modes, blink on hold release, pin nine source, detect polarity
    for (int b = 0; b < 2; b++) begin
      apb(1'h1, EXTENDED_MODE_CONTROL_ADDR, b ? 32'hF811 : 32'h0);
      sd = 4'($urandom);
      signal_detect_pins_i <= sd;
      fast_fail_i <= 1'h1;
      low_power_hold_input_i <= 1'h1;
      @(posedge clk_i);
      low_power_hold_input_i <= 1'h0;
      blinks = 0;
      repeat (6) begin
        @(negedge clk_i);
        blinks += led_blink_o;
      end
      chk("blink", b, blinks);
      chk("led", b ? 32'hF : 32'h0, 32'(led_ext_mode_o));
      chk("pin9", b ? 32'h3 : 32'h0, 32'({shared_io_pin_nine_o, shared_io_pin_nine_oe_o}));
      chk("sigdet", 32'(sd ^ {4{b[0]}}), 32'(signal_detect_o));
      @(posedge clk_i);
    end
    for (int x = 0; x < 4; x++) begin
      apb(1'h1, EXTENDED_MODE_CONTROL_ADDR, 32'(x) << CROSSOVER_LSB);
      settle();
      chk("xover", x == 1 ? 32'h0 : 32'(x), 32'(crossover_o));
      @(posedge clk_i);
    end
    // Low lane only: upper lane bits must stay clear; pin nine falls back to I/O
    pstrb_i <= 4'h1;
    shared_io_gpio_i <= 1'h1;
    shared_io_gpio_oe_i <= 1'h1;
    apb(1'h1, EXTENDED_MODE_CONTROL_ADDR, 32'hF800);
    pstrb_i <= 4'hF;
    rd(EXTENDED_MODE_CONTROL_ADDR, 32'h0, "strobe");
    chk("pin9 gpio", 32'h3, 32'({shared_io_pin_nine_o, shared_io_pin_nine_oe_o}));
    // Good packet count: read clears, wraps past 9999
    pkt_cnt = 3;
    ev(1'h0, 1'h0, 1'h1);
    rd(GOOD_CRC_COUNTER_ADDR, 1 << PKT_SEEN_BIT | pkt_cnt, "count");
    rd(GOOD_CRC_COUNTER_ADDR, 32'h0, "count clr");
    pkt_cnt = 10001;
    ev(1'h0, 1'h0, 1'h1);
    rd(GOOD_CRC_COUNTER_ADDR, 1 << PKT_SEEN_BIT | pkt_cnt % 10000, "wrap");
    // Interrupt: sticky, masked, raised, cleared by writing one
    rd(IRQ_STATUS_ADDR, 32'h7, "status");
    chk("irq masked", 32'h0, 32'(irq_o));
    apb(1'h1, IRQ_MASK_ADDR, 32'h1);
    settle();
    chk("irq up", 32'h1, 32'(irq_o));
    @(posedge clk_i);
    apb(1'h1, IRQ_STATUS_ADDR, 32'h1);
    rd(IRQ_STATUS_ADDR, 32'h6, "status w1c");
    chk("irq down", 32'h0, 32'(irq_o));
    tally_and_finish();
  end
endmodule : tb_phy_ext_page1_media_ctrl_regs
`default_nettype wire
